// ==== design/phase_if.sv ====
`timescale 1ns/1ps
interface phase_if;
  logic q1;
  logic q2;
  logic q3;
  logic q4;
  modport gen (output q1, output q2, output q3, output q4);
  modport use_ (input q1, input q2, input q3, input q4);
endinterface

// ==== design/q_phase_gen.sv ====
`timescale 1ns/1ps
module q_phase_gen
  import test_skip_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  phase_if.gen      ph
);

  // ***************************
  // four phase enables
  // ***************************
  logic [1:0] phaseCnt;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phaseCnt <= 2'h0;
    end else begin
      phaseCnt <= phaseCnt + 2'h1;
    end
  end

  // one-cycle enables, not derived clocks
  assign ph.q1 = (phaseCnt == 2'h0);
  assign ph.q2 = (phaseCnt == 2'h1);
  assign ph.q3 = (phaseCnt == 2'h2);
  assign ph.q4 = (phaseCnt == 2'h3);

  initial begin
    if (PHASES != 4) begin
      $error("phase generator serves four phases only");
    end
  end

endmodule

// ==== design/test_skip_and_table_write_exec.sv ====
// Contract
// - opcode 0110011 in bits 15:9 with 8-bit address is test-and-skip.
// - register zero: discard the prefetched instruction, run a no-operation cycle.
// - bank flag 0 takes the operand from the quick-access bank.
// - bank flag 1 puts the bank select value on upper address bits.
// - one cycle without skip, two with skip, extra cycle does nothing.
// - skip over a two-word instruction takes three cycles, both flushed.
// - post-increment write: latch to holding at pointer, then pointer plus one.
// - pre-increment write: pointer plus one, then latch to holding there.
`timescale 1ns/1ps
module test_skip_and_table_write_exec
  import test_skip_pkg::*;
#(
  parameter int HOLD_DEPTH = 8
)(
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic [INSTR_W-1:0]           instrWord,
  input  wire logic                         instrValid,
  input  wire logic                         nextTwoWord,
  output logic                              acceptInstr,
  input  wire logic [BSR_W-1:0]             bankSelect,
  output logic [ADDR_W-1:0]                 regAddr,
  output logic                              regRdEn,
  input  wire logic [DATA_W-1:0]            regRdData,
  input  wire logic [DATA_W-1:0]            tableDataLatch,
  input  wire logic                         ptrLoad,
  input  wire logic [PTR_W-1:0]             ptrLoadValue,
  output logic [PTR_W-1:0]                  tablePointer,
  output logic [HOLD_DEPTH-1:0][DATA_W-1:0] holdingBytes,
  output logic                              discardPrefetch,
  output logic                              nopCycle,
  output logic                              cycleDone,
  output logic                              statusWrEn
);

  localparam int HIDX_W = $clog2(HOLD_DEPTH);

  // refused at elaboration: the byte index is a plain slice of the pointer
  if (HOLD_DEPTH < 2 || (HOLD_DEPTH & (HOLD_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("holding depth must be a power of two, at least two");
  end

  // ***************************
  // phases
  // ***************************
  phase_if ph ();

  q_phase_gen u_phase (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ph      (ph)
  );

  // ***************************
  // decode helpers
  // ***************************
  function automatic logic is_skipz(input logic [INSTR_W-1:0] w);
    return w[OPC_HI:OPC_LO] == SKIPZ_OPC;
  endfunction

  function automatic logic is_tblwr(input logic [INSTR_W-1:0] w);
    return w[TBL_HI:TBL_LO] == TBLWR_OPC;
  endfunction

  function automatic logic [ADDR_W-1:0] operand_addr(input logic [INSTR_W-1:0] w,
                                                     input logic [BSR_W-1:0]   bank_select_register);
    logic [FADDR_W-1:0] f;
    f = w[FADDR_W-1:0];
    if (w[BANK_BIT]) begin
      operand_addr = {bank_select_register, f};
    end else if (f < ACCESS_SPLIT) begin
      operand_addr = {ACCESS_LO_BANK, f};
    end else begin
      operand_addr = {ACCESS_HI_BANK, f};
    end
  endfunction

  // ***************************
  // sequencer
  // ***************************
  typedef enum logic [1:0] {EXEC, FLUSH1, FLUSH2, TBL2} exec_state_t;
  exec_state_t state;
  exec_state_t next_state;

  logic              skipOp;
  logic              tblOp;
  ptr_mode_t         tblMode;
  logic              regZero;
  logic              flushSecond;
  logic              take;

  assign acceptInstr = (state == EXEC);
  assign take        = ph.q1 && instrValid && acceptInstr;
  assign nopCycle    = (state == FLUSH1) || (state == FLUSH2) || (state == TBL2);

  always_comb begin
    next_state = state;
    case (state)
      EXEC: begin
        if (skipOp && regZero) begin
          next_state = FLUSH1;
        end else if (tblOp) begin
          next_state = TBL2;
        end
      end
      FLUSH1: begin
        next_state = flushSecond ? FLUSH2 : EXEC;
      end
      FLUSH2:  next_state = EXEC;
      TBL2:    next_state = EXEC;
      default: next_state = EXEC;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= EXEC;
    end else if (ph.q4) begin
      state <= next_state;
    end
  end

  // latch the decoded instruction at Q1
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      skipOp  <= 1'b0;
      tblOp   <= 1'b0;
      tblMode <= PTR_KEEP;
      regAddr <= '0;
    end else if (ph.q1) begin
      skipOp  <= take && is_skipz(instrWord);
      tblOp   <= take && is_tblwr(instrWord);
      tblMode <= ptr_mode_t'(instrWord[1:0]);
      if (take && is_skipz(instrWord)) begin
        regAddr <= operand_addr(instrWord, bankSelect);
      end
    end
  end

  // read in Q2, test in Q3
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdEn <= 1'b0;
      regZero <= 1'b0;
    end else begin
      regRdEn <= ph.q1 && take && is_skipz(instrWord);
      if (ph.q3) begin
        regZero <= skipOp && (regRdData == ZERO_BYTE);
      end
    end
  end

  // word count of the discarded instruction is known only at Q4
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flushSecond     <= 1'b0;
      discardPrefetch <= 1'b0;
    end else begin
      discardPrefetch <= ph.q4 && (state == EXEC) && skipOp && regZero;
      if (ph.q4 && (state == EXEC)) begin
        flushSecond <= nextTwoWord;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cycleDone <= 1'b0;
    end else begin
      cycleDone <= ph.q4;
    end
  end

  // this block never writes the arithmetic flags
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      statusWrEn <= 1'b0;
    end else begin
      statusWrEn <= 1'b0;
    end
  end

  // ***************************
  // table pointer and holding bytes
  // ***************************
  logic [PTR_W-1:0]  writeAddr;
  logic [PTR_W-1:0]  next_pointer;
  logic              tblFire;

  assign tblFire = ph.q4 && (state == EXEC) && tblOp;

  always_comb begin
    writeAddr    = tablePointer;
    next_pointer = tablePointer;
    case (tblMode)
      PTR_POST_INC: next_pointer = tablePointer + PTR_ONE;
      PTR_POST_DEC: next_pointer = tablePointer - PTR_ONE;
      PTR_PRE_INC: begin
        next_pointer = tablePointer + PTR_ONE;
        writeAddr    = next_pointer;
      end
      default: next_pointer = tablePointer;
    endcase
  end

  // a core load wins over the write side effect in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tablePointer <= PTR_RESET;
    end else if (ptrLoad) begin
      tablePointer <= ptrLoadValue;
    end else if (tblFire) begin
      tablePointer <= next_pointer;
    end
  end

  // only the addressed byte changes; the latch is only read
  genvar gi;
  generate
    for (gi = 0; gi < HOLD_DEPTH; gi++) begin : g_hold
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          holdingBytes[gi] <= '1;
        end else if (tblFire && (writeAddr[HIDX_W-1:0] == HIDX_W'(gi))) begin
          holdingBytes[gi] <= tableDataLatch;
        end
      end
    end
  endgenerate

  // ***************************
  // checks
  // ***************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence skip_decided;
    ph.q4 && (state == EXEC) && skipOp && regZero;
  endsequence

  sequence no_skip_end;
    ph.q4 && (state == EXEC) && !(skipOp && regZero) && !tblOp;
  endsequence

  decode_opcode_a: assert property (take && is_skipz(instrWord) |=> skipOp)
    else $error("skip opcode not recognised");
  quick_bank_a: assert property (take && is_skipz(instrWord) && !instrWord[BANK_BIT]
      |=> regAddr[ADDR_W-1:FADDR_W] == ((regAddr[FADDR_W-1:0] < ACCESS_SPLIT)
          ? ACCESS_LO_BANK : ACCESS_HI_BANK))
    else $error("quick bank address wrong");
  banked_addr_a: assert property (take && is_skipz(instrWord) && instrWord[BANK_BIT]
      |=> regAddr[ADDR_W-1:FADDR_W] == $past(bankSelect))
    else $error("bank select not used");
  discard_on_zero_a: assert property (skip_decided |=> discardPrefetch ##1 nopCycle)
    else $error("zero did not discard prefetch");
  one_cycle_a: assert property (no_skip_end |=> !nopCycle [*4])
    else $error("unskipped test took extra cycle");
  skip_two_a: assert property ((skip_decided and !nextTwoWord)
      |=> nopCycle [*4] ##1 !nopCycle)
    else $error("skip length not two cycles");
  skip_three_a: assert property ((skip_decided and nextTwoWord)
      |=> nopCycle [*8] ##1 !nopCycle)
    else $error("two-word skip not three cycles");
  post_inc_a: assert property (tblFire && tblMode == PTR_POST_INC && !ptrLoad
      |=> tablePointer == $past(tablePointer) + PTR_ONE
          && holdingBytes[$past(tablePointer[HIDX_W-1:0])] == $past(tableDataLatch))
    else $error("post-increment write wrong");
  pre_inc_a: assert property (tblFire && tblMode == PTR_PRE_INC && !ptrLoad
      |=> tablePointer == $past(tablePointer) + PTR_ONE
          && holdingBytes[tablePointer[HIDX_W-1:0]] == $past(tableDataLatch))
    else $error("pre-increment write wrong");
  no_flags_a: assert property (skipOp |-> !statusWrEn)
    else $error("status written by test");

endmodule

// ==== design/test_skip_pkg.sv ====
package test_skip_pkg;

  // ***************************
  // widths
  // ***************************
  localparam int INSTR_W = 16;
  localparam int PTR_W   = 21;
  localparam int BSR_W   = 4;
  localparam int FADDR_W = 8;
  localparam int ADDR_W  = BSR_W + FADDR_W;
  localparam int DATA_W  = 8;

  // ***************************
  // instruction fields
  // ***************************
  localparam int OPC_HI   = 15;
  localparam int OPC_LO   = 9;
  localparam int BANK_BIT = 8;
  localparam int TBL_HI   = 15;
  localparam int TBL_LO   = 2;

  localparam logic [6:0]  SKIPZ_OPC = 7'h33;
  localparam logic [13:0] TBLWR_OPC = 14'h0003;

  // ***************************
  // access bank split
  // ***************************
  localparam logic [FADDR_W-1:0] ACCESS_SPLIT   = 8'h80;
  localparam logic [BSR_W-1:0]   ACCESS_LO_BANK = 4'h0;
  localparam logic [BSR_W-1:0]   ACCESS_HI_BANK = 4'hF;

  // ***************************
  // pointer modes and phases
  // ***************************
  typedef enum logic [1:0] {
    PTR_KEEP     = 2'h0,
    PTR_POST_INC = 2'h1,
    PTR_POST_DEC = 2'h2,
    PTR_PRE_INC  = 2'h3
  } ptr_mode_t;

  localparam int PHASES = 4;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [PTR_W-1:0]  PTR_ONE   = 21'h000001;
  localparam logic [PTR_W-1:0]  PTR_RESET = 21'h000000;

endpackage

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb
  import test_skip_pkg::*;
;
  // ***************************
  // stimulus rows
  // ***************************
  typedef struct {
    logic [INSTR_W-1:0] w;
    logic [BSR_W-1:0]   bs;
    logic [DATA_W-1:0]  rd;
    logic               two;
    logic               ld;
    logic               poke;
    logic [PTR_W-1:0]   lv;
    logic [DATA_W-1:0]  lat;
    logic [ADDR_W-1:0]  ea;
    int                 en;
    int                 ds;
    int                 nop;
    logic [PTR_W-1:0]   ep;
    int                 hi;
    logic [DATA_W-1:0]  hv;
  } row_t;

  logic                     ref_clk = 1'b0;
  logic                     rst = 1'b1;
  logic [INSTR_W-1:0]       instrWord = 16'h0000;
  logic                     instrValid = 1'b0;
  logic                     nextTwoWord = 1'b0;
  logic                     acceptInstr;
  logic [BSR_W-1:0]         bankSelect = 4'h0;
  logic [ADDR_W-1:0]        regAddr;
  logic                     regRdEn;
  logic [DATA_W-1:0]        regRdData = 8'h00;
  logic [DATA_W-1:0]        tableDataLatch = 8'h00;
  logic                     ptrLoad = 1'b0;
  logic [PTR_W-1:0]         ptrLoadValue = 21'h000000;
  logic [PTR_W-1:0]         tablePointer;
  logic [7:0][DATA_W-1:0]   holdingBytes;
  logic                     discardPrefetch;
  logic                     nopCycle;
  logic                     cycleDone;
  logic                     statusWrEn;
  int                       failures = 0;
  int                       cmp_count = 0;
  int                       cycles = 0;
  row_t                     rows [10];

  always #12.5 ref_clk = ~ref_clk;

  test_skip_and_table_write_exec #(.HOLD_DEPTH(8)) DUT (
    .ref_clk(ref_clk), .rst(rst), .instrWord(instrWord), .instrValid(instrValid),
    .nextTwoWord(nextTwoWord), .acceptInstr(acceptInstr), .bankSelect(bankSelect),
    .regAddr(regAddr), .regRdEn(regRdEn), .regRdData(regRdData),
    .tableDataLatch(tableDataLatch), .ptrLoad(ptrLoad), .ptrLoadValue(ptrLoadValue),
    .tablePointer(tablePointer), .holdingBytes(holdingBytes),
    .discardPrefetch(discardPrefetch), .nopCycle(nopCycle), .cycleDone(cycleDone),
    .statusWrEn(statusWrEn)
  );

  // ***************************
  // checking and closing
  // ***************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard: the whole run needs well under 300 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      close_out();
    end
  end

  // caller sits at the edge just before a Q1 edge; returns at such an edge 16 clocks later
  task automatic run_op(input row_t r);
    int en;
    int ds;
    int nop;
    int busy;
    int cd;
    logic st;
    en = 0;
    ds = 0;
    nop = 0;
    busy = 0;
    cd = 0;
    st = 1'b0;
    instrWord <= r.w;
    instrValid <= 1'b1;
    bankSelect <= r.bs;
    regRdData <= r.rd;
    nextTwoWord <= r.two;
    ptrLoad <= r.ld;
    ptrLoadValue <= r.lv;
    tableDataLatch <= r.lat;
    @(posedge ref_clk);
    instrValid <= 1'b0;
    ptrLoad <= 1'b0;
    // the read pulse stands in the clock right after the take edge
    for (int i = 1; i < 15; i++) begin
      @(negedge ref_clk);
      en += (regRdEn === 1'b1);
      ds += (discardPrefetch === 1'b1);
      nop += (nopCycle === 1'b1);
      busy += (acceptInstr === 1'b0);
      cd += (cycleDone === 1'b1);
      st |= (statusWrEn !== 1'b0);
      @(posedge ref_clk);
      // a request during the flushed cycle must be ignored
      if (r.poke && i == 3) begin
        instrWord <= 16'h6722;
        instrValid <= 1'b1;
      end
      if (i == 4) begin
        instrValid <= 1'b0;
      end
    end
    @(negedge ref_clk);
    chk("regAddr", r.ea, regAddr);
    chk("readPulses", r.en, en);
    chk("discards", r.ds, ds);
    chk("nopClocks", r.nop, nop);
    chk("statusWrite", 0, st);
    chk("pointer", r.ep, tablePointer);
    chk("holding", r.hv, holdingBytes[r.hi]);
    chk("busyClocks", r.nop, busy);
    chk("cycleEnds", 3, cd);
    @(posedge ref_clk);
  endtask

  // ***************************
  // main sequence
  // ***************************
  initial begin
    rows[0] = '{16'h6605, 4'h3, 8'h00, 1'b0, 1'b0, 1'b0, PTR_RESET, 8'h00, 12'h005, 1, 1, 4,
                PTR_RESET, 7, 8'hFF};
    rows[1] = '{16'h6790, 4'h3, 8'h07, 1'b0, 1'b0, 1'b0, PTR_RESET, 8'h00, 12'h390, 1, 0, 0,
                PTR_RESET, 7, 8'hFF};
    rows[2] = '{16'h6690, 4'h3, 8'h00, 1'b1, 1'b0, 1'b0, PTR_RESET, 8'h00, 12'hF90, 1, 1, 8,
                PTR_RESET, 7, 8'hFF};
    rows[3] = '{16'h67FF, 4'hA, 8'h80, 1'b0, 1'b0, 1'b0, PTR_RESET, 8'h00, 12'hAFF, 1, 0, 0,
                PTR_RESET, 7, 8'hFF};
    rows[4] = '{16'h6805, 4'hA, 8'h00, 1'b0, 1'b0, 1'b0, PTR_RESET, 8'h00, 12'hAFF, 0, 0, 0,
                PTR_RESET, 7, 8'hFF};
    rows[5] = '{16'h6601, 4'h0, 8'h00, 1'b0, 1'b0, 1'b1, PTR_RESET, 8'h00, 12'h001, 1, 1, 4,
                PTR_RESET, 7, 8'hFF};
    rows[6] = '{16'h000D, 4'h0, 8'h00, 1'b0, 1'b1, 1'b0, 21'h00A356, 8'h55, 12'h001, 0, 0, 4,
                21'h00A357, 6, 8'h55};
    rows[7] = '{16'h000F, 4'h0, 8'h00, 1'b0, 1'b1, 1'b0, 21'h01389A, 8'h34, 12'h001, 0, 0, 4,
                21'h01389B, 3, 8'h34};
    rows[8] = '{16'h000C, 4'h0, 8'h00, 1'b0, 1'b1, 1'b0, 21'h000011, 8'hA5, 12'h001, 0, 0, 4,
                21'h000011, 1, 8'hA5};
    // pre-increment above left byte 2 alone; post-decrement writes byte 0 only
    rows[9] = '{16'h000E, 4'h0, 8'h00, 1'b0, 1'b1, 1'b0, 21'h000020, 8'h3C, 12'h001, 0, 0, 4,
                21'h00001F, 2, 8'hFF};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      run_op(rows[i]);
    end
    chk("postDecByte", 8'h3C, holdingBytes[0]);
    rst <= 1'b1;
    @(negedge ref_clk);
    chk("resetPointer", PTR_RESET, tablePointer);
    chk("resetHolding", 8'hFF, holdingBytes[6]);
    chk("resetAccept", 1'b1, acceptInstr);
    chk("resetNop", 1'b0, nopCycle);
    // second release: the phase count must restart at Q1
    @(posedge ref_clk);
    rst <= 1'b0;
    run_op(rows[5]);
    close_out();
  end
endmodule
